/* ldss_pkg.sv */
// constants, types and timing for the led driver switch sequencer
// Operation
// - at 18V start, latch thermal threshold first, then enable switching
// - supply below 7.2V lockout stops all gate switching at once
// - gate off once primary current reaches the regulation peak threshold
// - gate on again when aux sense falls below 0V in off-time
// - minimum off-time; valley detections before it are ignored
// - sample aux sense exactly one off-state blanking after gate off
// - aux sense above 3.6V three times stops switching until lockout
// - supply above 29V three consecutive periods stops switching until lockout
// - after overvoltage trip hold gate off 300ms, then discharge and restart
// - max off timeouts for 10 to 20ms trip short circuit, restart after 300ms
// - short-circuit trip and restart repeats while the short persists
// - current sense above 1.8V turns the switch off in that cycle
// - after a max off-time timeout the next cycle limit is 0.8V
// - thermal threshold from resistor ratio: 79.4 at zero up to 135.2 open
// - soft start: ramp on-time limit so no current spikes at start
// - status shows the operating mode, valley start or timeout start, with no configuration
// - off-state blanking before aux sampling lasts 2.1 microseconds
// - ignore current sense for 240ns after each gate turn-on
package ldss_pkg;
    localparam int CLK_MHZ = 40;
    // times in their own units
    localparam int OFF_BLANK_NS = 2100;
    localparam int CS_BLANK_NS = 240;
    localparam int MIN_OFF_NS = 2500;
    localparam int TON_MAX_US = 25;
    localparam int OFF_MAX_US = 250;
    localparam int FAULT_HOLD_MS = 300;
    localparam int SHORT_MIN_MS = 10;
    // derived cycle counts, least times rounded up
    localparam logic [23:0] OFF_BLANK_CYC = 24'((OFF_BLANK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [23:0] CS_BLANK_CYC = 24'((CS_BLANK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [23:0] MIN_OFF_CYC = 24'((MIN_OFF_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] TON_MAX_CYC = 10'(TON_MAX_US * CLK_MHZ);
    localparam logic [23:0] OFF_MAX_CYC = 24'(OFF_MAX_US * CLK_MHZ);
    localparam logic [23:0] FAULT_HOLD_CYC = 24'(FAULT_HOLD_MS * 1000 * CLK_MHZ);
    // timeouts in a row that cover at least the short-circuit window
    localparam logic [5:0] SHORT_TIMEOUTS =
        6'((SHORT_MIN_MS * 1000 + OFF_MAX_US - 1) / OFF_MAX_US);
    localparam logic [1:0] OV_EVENTS = 2'h3;
    // soft-start on-time limit: first value and growth per cycle
    localparam logic [9:0] SS_START_CYC = 10'h064;
    localparam logic [9:0] SS_STEP_CYC = 10'h004;
    // thermal threshold in tenths of a degree, by ratio code 0..7 (7 = open)
    localparam logic [10:0] THERMAL_TBL [8] = '{
        11'h31A, 11'h361, 11'h3AA, 11'h3F6, 11'h445, 11'h498, 11'h4EE, 11'h548
    };
    localparam logic [10:0] THERMAL_RST = 11'h548;

    typedef enum logic [2:0] {
        ST_LOCK = 3'h0,
        ST_SENSE = 3'h1,
        ST_ON = 3'h3,
        ST_OFF = 3'h2,
        ST_HOLD = 3'h6,
        ST_DISCH = 3'h7
    } ldss_state_t;

    // comparator outputs from the analog front end
    typedef struct packed {
        logic supply_start;     // supply at or above 18V
        logic supply_lockout;   // supply below 7.2V
        logic supply_ov;        // supply above 29V
        logic cs_peak;          // current at sense_reference peak
        logic cs_ocp_hi;        // current sense above 1.8V
        logic cs_ocp_lo;        // current sense above 0.8V
        logic aux_below_zero;   // aux_winding_sense below 0V
        logic aux_ov;           // aux_winding_sense above 3.6V
    } ldss_cmp_t;

    typedef struct packed {
        logic overvoltage_trip;
        logic short_circuit_trip;
        logic supply_discharge;
        logic quasi_resonant_operation; // 0 = critical_conduction
    } ldss_stat_t;
endpackage : ldss_pkg

/* ldss_thermal_latch.sv */
// thermal_regulation threshold latch, loaded once per start-up
`timescale 1ns/100ps
module ldss_thermal_latch (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic load_i,
    input wire logic [2:0] ratio_code_i,
    output logic [10:0] threshold_o
);
    logic [10:0] thr_d;
    logic [10:0] thr_q;

    // table lookup, monotonic in the ratio code
    always_comb
    begin
        thr_d = thr_q;
        if (load_i)
        begin
            thr_d = ldss_pkg::THERMAL_TBL[ratio_code_i];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            thr_q <= ldss_pkg::THERMAL_RST;
        end
        else
        begin
            thr_q <= thr_d;
        end
    end

    assign threshold_o = thr_q;
endmodule : ldss_thermal_latch

/* ldss_sequencer.sv */
// gate switching sequencer and fault supervisor
`timescale 1ns/100ps
module ldss_sequencer #(
    parameter logic [23:0] OFF_MAX_CYC = ldss_pkg::OFF_MAX_CYC,
    parameter logic [23:0] FAULT_HOLD_CYC = ldss_pkg::FAULT_HOLD_CYC
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire ldss_pkg::ldss_cmp_t cmp_i,
    input wire logic [2:0] thermal_set_pin_i,
    output logic gate_drive_out_o,
    output logic [10:0] thermal_threshold_o,
    output ldss_pkg::ldss_stat_t status_o
);
    ldss_pkg::ldss_state_t state_d;
    ldss_pkg::ldss_state_t state_q;
    logic [23:0] cnt_d;
    logic [23:0] cnt_q;
    logic gate_d;
    logic gate_q;
    logic [1:0] aux_ov_cnt_d;
    logic [1:0] aux_ov_cnt_q;
    logic [1:0] vdd_ov_cnt_d;
    logic [1:0] vdd_ov_cnt_q;
    logic [5:0] short_cnt_d;
    logic [5:0] short_cnt_q;
    logic tmo_d;
    logic tmo_q;
    logic [9:0] on_lim_d;
    logic [9:0] on_lim_q;
    logic aux_neg_q;
    logic load_thr;
    logic valley;
    logic blank_done;
    logic ocp;
    logic start_cycle;
    ldss_pkg::ldss_stat_t stat_d;
    ldss_pkg::ldss_stat_t stat_q;

    ldss_thermal_latch u_thermal (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .load_i(load_thr),
        .ratio_code_i(thermal_set_pin_i),
        .threshold_o(thermal_threshold_o)
    );

    // falling aux edge, only honoured after the minimum off-time
    assign valley = cmp_i.aux_below_zero && !aux_neg_q
        && (cnt_q >= ldss_pkg::MIN_OFF_CYC);
    assign blank_done = cnt_q >= ldss_pkg::CS_BLANK_CYC;
    // reduced limit after a timeout keeps short-circuit probing gentle
    assign ocp = tmo_q ? cmp_i.cs_ocp_lo : cmp_i.cs_ocp_hi;

    // next state of the switching sequence and fault bookkeeping
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q + 24'h1;
        gate_d = 1'b0;
        aux_ov_cnt_d = aux_ov_cnt_q;
        vdd_ov_cnt_d = vdd_ov_cnt_q;
        short_cnt_d = short_cnt_q;
        tmo_d = tmo_q;
        on_lim_d = on_lim_q;
        stat_d = stat_q;
        stat_d.supply_discharge = 1'b0;
        load_thr = 1'b0;
        start_cycle = 1'b0;
        case (state_q)
            ldss_pkg::ST_LOCK:
            begin
                cnt_d = 24'h0;
                aux_ov_cnt_d = 2'h0;
                vdd_ov_cnt_d = 2'h0;
                short_cnt_d = 6'h0;
                tmo_d = 1'b0;
                on_lim_d = ldss_pkg::SS_START_CYC;
                stat_d = '0;
                if (cmp_i.supply_start && !cmp_i.supply_lockout)
                begin
                    state_d = ldss_pkg::ST_SENSE;
                end
            end
            ldss_pkg::ST_SENSE:
            begin
                load_thr = 1'b1;
                state_d = ldss_pkg::ST_ON;
                cnt_d = 24'h0;
                gate_d = 1'b1;
            end
            ldss_pkg::ST_ON:
            begin
                gate_d = 1'b1;
                // sense ignored during leading-edge blanking
                if ((blank_done && (cmp_i.cs_peak || ocp))
                    || (cnt_q >= {14'h0, on_lim_q} - 24'h1))
                begin
                    state_d = ldss_pkg::ST_OFF;
                    gate_d = 1'b0;
                    cnt_d = 24'h0;
                    if (on_lim_q < ldss_pkg::TON_MAX_CYC)
                    begin
                        on_lim_d = on_lim_q + ldss_pkg::SS_STEP_CYC;
                    end
                end
            end
            ldss_pkg::ST_OFF:
            begin
                if (valley)
                begin
                    start_cycle = 1'b1;
                    tmo_d = 1'b0;
                    short_cnt_d = 6'h0;
                    stat_d.quasi_resonant_operation = 1'b0;
                end
                else if (cnt_q >= OFF_MAX_CYC - 24'h1)
                begin
                    start_cycle = 1'b1;
                    tmo_d = 1'b1;
                    short_cnt_d = short_cnt_q + 6'h1;
                    stat_d.quasi_resonant_operation = 1'b1;
                    if (short_cnt_q == ldss_pkg::SHORT_TIMEOUTS - 6'h1)
                    begin
                        stat_d.short_circuit_trip = 1'b1;
                        start_cycle = 1'b0;
                        state_d = ldss_pkg::ST_HOLD;
                        cnt_d = 24'h0;
                    end
                end
                // output voltage sample, one blanking after turn-off
                if (cnt_q == ldss_pkg::OFF_BLANK_CYC && cmp_i.aux_ov)
                begin
                    aux_ov_cnt_d = aux_ov_cnt_q + 2'h1;
                    if (aux_ov_cnt_q == ldss_pkg::OV_EVENTS - 2'h1)
                    begin
                        stat_d.overvoltage_trip = 1'b1;
                        start_cycle = 1'b0;
                        state_d = ldss_pkg::ST_HOLD;
                        cnt_d = 24'h0;
                    end
                end
                // supply overvoltage checked once per switching period
                if (start_cycle)
                begin
                    vdd_ov_cnt_d = cmp_i.supply_ov ? vdd_ov_cnt_q + 2'h1 : 2'h0;
                    if (cmp_i.supply_ov && vdd_ov_cnt_q == ldss_pkg::OV_EVENTS - 2'h1)
                    begin
                        stat_d.overvoltage_trip = 1'b1;
                        start_cycle = 1'b0;
                        state_d = ldss_pkg::ST_HOLD;
                        cnt_d = 24'h0;
                    end
                end
                if (start_cycle)
                begin
                    state_d = ldss_pkg::ST_ON;
                    gate_d = 1'b1;
                    cnt_d = 24'h0;
                end
            end
            ldss_pkg::ST_HOLD:
            begin
                // gate stays off for the full hold time
                if (cnt_q >= FAULT_HOLD_CYC - 24'h1)
                begin
                    state_d = ldss_pkg::ST_DISCH;
                end
            end
            ldss_pkg::ST_DISCH:
            begin
                cnt_d = 24'h0;
                stat_d.supply_discharge = 1'b1;
            end
            default:
            begin
                state_d = ldss_pkg::ST_LOCK;
            end
        endcase
        // lockout overrides state, gate and count; the only way back is a fresh start
        if (cmp_i.supply_lockout && state_q != ldss_pkg::ST_LOCK)
        begin
            state_d = ldss_pkg::ST_LOCK;
            gate_d = 1'b0;
            cnt_d = 24'h0;
        end
    end

    // register every piece of sequencer state
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            state_q <= ldss_pkg::ST_LOCK;
            cnt_q <= 24'h0;
            gate_q <= 1'b0;
            aux_ov_cnt_q <= 2'h0;
            vdd_ov_cnt_q <= 2'h0;
            short_cnt_q <= 6'h0;
            tmo_q <= 1'b0;
            on_lim_q <= ldss_pkg::SS_START_CYC;
            aux_neg_q <= 1'b0;
            stat_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            gate_q <= gate_d;
            aux_ov_cnt_q <= aux_ov_cnt_d;
            vdd_ov_cnt_q <= vdd_ov_cnt_d;
            short_cnt_q <= short_cnt_d;
            tmo_q <= tmo_d;
            on_lim_q <= on_lim_d;
            aux_neg_q <= cmp_i.aux_below_zero;
            stat_q <= stat_d;
        end
    end

    assign gate_drive_out_o = gate_q;
    assign status_o = stat_q;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_sense_then_on;
        state_q == ldss_pkg::ST_SENSE ##1 state_q == ldss_pkg::ST_ON;
    endsequence

    sequence s_lock_settled;
        state_q == ldss_pkg::ST_LOCK ##1 state_q == ldss_pkg::ST_LOCK;
    endsequence

    a_start_after_latch: assert property (
        s_sense_then_on |-> gate_drive_out_o
            && thermal_threshold_o == ldss_pkg::THERMAL_TBL[$past(thermal_set_pin_i)])
        else $error("switching began without latching the thermal threshold");

    a_lockout_gate_off: assert property (
        cmp_i.supply_lockout |=> !gate_drive_out_o [*2])
        else $error("gate drive active during supply lockout");

    a_peak_turn_off: assert property (
        state_q == ldss_pkg::ST_ON && blank_done && cmp_i.cs_peak |=> !gate_drive_out_o)
        else $error("gate stayed on after peak current");

    a_cs_blanking: assert property (
        state_q == ldss_pkg::ST_ON && cnt_q < ldss_pkg::CS_BLANK_CYC
            && !cmp_i.supply_lockout && cnt_q < {14'h0, on_lim_q} - 24'h1
            |=> state_q == ldss_pkg::ST_ON)
        else $error("current sense acted inside blanking");

    a_valley_turn_on: assert property (
        state_q == ldss_pkg::ST_OFF && valley && !cmp_i.supply_lockout
            && !cmp_i.supply_ov && !(cnt_q == ldss_pkg::OFF_BLANK_CYC && cmp_i.aux_ov)
            |=> gate_drive_out_o)
        else $error("valley did not turn the gate on");

    a_min_off_hold: assert property (
        state_q == ldss_pkg::ST_OFF && cnt_q < ldss_pkg::MIN_OFF_CYC
            |=> state_q != ldss_pkg::ST_ON)
        else $error("gate turned on before minimum off-time");

    a_aux_ov_trip: assert property (
        state_q == ldss_pkg::ST_OFF && cnt_q == ldss_pkg::OFF_BLANK_CYC && cmp_i.aux_ov
            && aux_ov_cnt_q == 2'h2 && !cmp_i.supply_lockout
            |=> state_q == ldss_pkg::ST_HOLD && status_o.overvoltage_trip)
        else $error("third aux overvoltage sample did not trip");

    a_hold_gate_off: assert property (
        state_q == ldss_pkg::ST_HOLD |-> !gate_drive_out_o ##1 !gate_drive_out_o)
        else $error("gate switched during fault hold");

    a_short_trip: assert property (
        state_q == ldss_pkg::ST_OFF && !valley && cnt_q >= OFF_MAX_CYC - 24'h1
            && short_cnt_q == ldss_pkg::SHORT_TIMEOUTS - 6'h1 && !cmp_i.supply_lockout
            |=> state_q == ldss_pkg::ST_HOLD && status_o.short_circuit_trip)
        else $error("short circuit not tripped after timeout run");

    a_ocp_reduced: assert property (
        state_q == ldss_pkg::ST_ON && blank_done && tmo_q && cmp_i.cs_ocp_lo
            |=> state_q != ldss_pkg::ST_ON)
        else $error("reduced current limit ignored after timeout");

    a_ocp_full_limit: assert property (
        state_q == ldss_pkg::ST_ON && blank_done && !tmo_q && cmp_i.cs_ocp_hi
            |=> !gate_drive_out_o)
        else $error("gate stayed on above the full current limit");

    a_supply_ov_trip: assert property (
        state_q == ldss_pkg::ST_OFF && valley && cmp_i.supply_ov && vdd_ov_cnt_q == 2'h2
            && !cmp_i.supply_lockout
            |=> state_q == ldss_pkg::ST_HOLD && status_o.overvoltage_trip)
        else $error("third supply overvoltage period did not trip");

    // counter only moves at the one sample point of each off-time
    a_ov_sample_point: assert property (
        state_q == ldss_pkg::ST_OFF && cnt_q != ldss_pkg::OFF_BLANK_CYC
            |=> aux_ov_cnt_q == $past(aux_ov_cnt_q))
        else $error("aux overvoltage sampled away from the blanking point");

    a_discharge_req: assert property (
        state_q == ldss_pkg::ST_DISCH && !cmp_i.supply_lockout |=> status_o.supply_discharge)
        else $error("supply discharge not requested after hold");

    a_restart_clean: assert property (
        s_lock_settled |-> aux_ov_cnt_q == 2'h0 && vdd_ov_cnt_q == 2'h0 && short_cnt_q == 6'h0)
        else $error("fault counters not cleared in lockout");
endmodule : ldss_sequencer

/* ldss_far_side_model.sv */
// far-side model: switch current ramp and auxiliary winding ringing
`timescale 1ns/100ps
module ldss_far_side_model (
    input wire logic mclk_i,
    input wire logic gate_i,
    input wire logic [9:0] peak_cyc_i,
    input wire logic [9:0] hi_cyc_i,
    input wire logic [9:0] lo_cyc_i,
    input wire logic [9:0] valley_cyc_i,
    input wire logic [9:0] ov_lo_i,
    input wire logic ov_en_i,
    output logic cs_peak_o,
    output logic cs_hi_o,
    output logic cs_lo_o,
    output logic aux_low_o,
    output logic aux_ov_o
);
    int on_cnt = 0;
    int off_cnt = 0;

    // cycles since the last gate change, counted away from the design edge
    always @(negedge mclk_i)
    begin
        on_cnt = gate_i ? on_cnt + 1 : 0;
        off_cnt = gate_i ? 0 : off_cnt + 1;
    end

    // a count of 3FF is never reached, so it stands for an absent event
    assign cs_peak_o = on_cnt >= peak_cyc_i;
    assign cs_hi_o = on_cnt >= hi_cyc_i;
    assign cs_lo_o = on_cnt >= lo_cyc_i;
    // ringing falls below zero once per off-time and stays low until turn-on
    assign aux_low_o = off_cnt >= valley_cyc_i;
    // high aux level only inside a short window of the off-time
    assign aux_ov_o = ov_en_i && off_cnt >= ov_lo_i && off_cnt <= ov_lo_i + 12;
endmodule : ldss_far_side_model

/* test_ldss_sequencer.sv */
// self-checking testbench for the switching sequencer
`timescale 1ns/100ps
module test_ldss_sequencer;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic s_start = 1'b0;
    logic s_lock = 1'b0;
    logic s_ov = 1'b0;
    logic [2:0] tpin = 3'h7;
    logic [9:0] pk = 10'h01E;
    logic [9:0] hi = 10'h3FF;
    logic [9:0] lo = 10'h3FF;
    logic [9:0] vl = 10'h078;
    logic [9:0] ovl = 10'h064;
    logic oven = 1'b0;
    logic cs_pk, cs_hi, cs_lo, aux_lo, aux_ov, gate;
    logic [10:0] thr;
    ldss_pkg::ldss_stat_t st;
    ldss_pkg::ldss_cmp_t cmp;
    int miscompares = 0;
    int check_count = 0;
    // threshold in tenths of a degree for each ratio code
    logic [10:0] thr_exp [8] = '{11'h31A, 11'h361, 11'h3AA, 11'h3F6,
        11'h445, 11'h498, 11'h4EE, 11'h548};

    // comparator bundle in the order of the struct members
    assign cmp = {s_start, s_lock, s_ov, cs_pk, cs_hi, cs_lo, aux_lo, aux_ov};

    // short timeout and hold keep the fault runs brief
    ldss_sequencer #(.OFF_MAX_CYC(24'h0000C8), .FAULT_HOLD_CYC(24'h0001F4)) u_ldss_sequencer (
        .mclk_i(mclk_i), .reset_i(reset_i), .cmp_i(cmp), .thermal_set_pin_i(tpin),
        .gate_drive_out_o(gate), .thermal_threshold_o(thr), .status_o(st));

    ldss_far_side_model u_ldss_far_side_model (
        .mclk_i(mclk_i), .gate_i(gate), .peak_cyc_i(pk), .hi_cyc_i(hi), .lo_cyc_i(lo),
        .valley_cyc_i(vl), .ov_lo_i(ovl), .ov_en_i(oven), .cs_peak_o(cs_pk),
        .cs_hi_o(cs_hi), .cs_lo_o(cs_lo), .aux_low_o(aux_lo), .aux_ov_o(aux_ov));

    // 40 MHz clock
    initial
    begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : chk

    // count falling edges until the gate reaches lvl or a trip shows
    task automatic tick_to(input logic lvl, output int n, output bit trip);
        n = 0;
        trip = 1'b0;
        while (gate !== lvl && !trip)
        begin
            @(negedge mclk_i);
            n++;
            trip = st.overvoltage_trip === 1'b1 || st.short_circuit_trip === 1'b1;
            if (n > 1500)
            begin
                chk(1'b0, "gate wait ran out");
                print_verdict();
            end
        end
    endtask : tick_to

    // one switching period: on-time, then off-time up to the next turn-on
    task automatic run_cyc(output int ton, output int toff, output bit trip);
        int w;
        toff = 0;
        ton = 0;
        tick_to(1'b1, w, trip);
        if (trip)
            return;
        tick_to(1'b0, ton, trip);
        tick_to(1'b1, toff, trip);
    endtask : run_cyc

    task automatic start(input logic [2:0] code);
        tpin = code;
        s_start = 1'b1;
        @(negedge mclk_i);
        s_start = 1'b0;
        // one sense cycle: threshold load and first turn-on share the next edge
        chk(gate === 1'b0, "no switching while sensing");
        @(negedge mclk_i);
        chk(gate === 1'b1 && thr === thr_exp[code], "switching with threshold latched");
    endtask : start

    task automatic lock();
        s_lock = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk(gate === 1'b0, "gate off in lockout");
        chk(st === 4'h0, "status cleared by lockout");
        s_lock = 1'b0;
        @(negedge mclk_i);
    endtask : lock

    // gate must stay low for the whole hold, then discharge is requested
    task automatic hold_chk();
        int n;
        bit bad;
        n = 0;
        bad = 1'b0;
        while (st.supply_discharge !== 1'b1 && n < 2000)
        begin
            @(negedge mclk_i);
            n++;
            bad |= gate !== 1'b0;
        end
        chk(!bad && n >= 490 && n <= 510, "hold before discharge");
        if (n >= 2000)
            print_verdict();
    endtask : hold_chk

    task automatic t_thermal();
        chk(gate === 1'b0 && st === 4'h0 && thr === 11'h548, "reset values");
        for (int c = 0; c < 8; c++)
        begin
            start(3'(c));
            lock();
        end
        $display("test thermal done");
    endtask : t_thermal

    task automatic t_switch();
        int t1, t2, f;
        bit tr;
        pk = 10'h3FF;
        start(3'h7);
        run_cyc(t1, f, tr);
        run_cyc(t2, f, tr);
        chk(t1 >= 98 && t1 <= 103 && t2 - t1 == 4, "soft start ramp");
        pk = 10'h01E;
        run_cyc(t1, f, tr);
        run_cyc(t1, f, tr);
        chk(t1 >= 30 && t1 <= 32, "off at peak current");
        chk(f >= 120 && f <= 124, "on again at valley");
        chk(st.quasi_resonant_operation === 1'b0, "valley start mode");
        pk = 10'h001;
        vl = 10'h014;
        run_cyc(t1, f, tr);
        chk(t1 >= 10 && t1 <= 14, "sense blanked after turn-on");
        chk(f >= 195 && f <= 204, "early valley ignored");
        @(negedge mclk_i);
        chk(st.quasi_resonant_operation === 1'b1, "timeout start mode");
        $display("test switching done");
    endtask : t_switch

    task automatic t_ocp();
        int t, f;
        bit tr;
        pk = 10'h050;
        hi = 10'h028;
        vl = 10'h078;
        run_cyc(t, f, tr);
        run_cyc(t, f, tr);
        chk(t >= 40 && t <= 42, "high current limit");
        hi = 10'h3FF;
        lo = 10'h028;
        run_cyc(t, f, tr);
        run_cyc(t, f, tr);
        chk(t >= 80 && t <= 82, "low limit unused after valley");
        vl = 10'h3FF;
        run_cyc(t, f, tr);
        run_cyc(t, f, tr);
        chk(t >= 40 && t <= 42, "low limit after timeout");
        lo = 10'h3FF;
        vl = 10'h078;
        lock();
        $display("test current limit done");
    endtask : t_ocp

    task automatic t_ov();
        int t, f, n;
        bit tr;
        start(3'h7);
        oven = 1'b1;
        repeat (5) run_cyc(t, f, tr);
        chk(!tr && st.overvoltage_trip === 1'b0, "late aux level not sampled");
        ovl = 10'h04E;
        run_cyc(t, f, tr);
        run_cyc(t, f, tr);
        chk(!tr, "two aux samples tolerated");
        run_cyc(t, f, tr);
        chk(tr && st.overvoltage_trip === 1'b1, "third aux sample trips");
        hold_chk();
        oven = 1'b0;
        lock();
        start(3'h7);
        s_ov = 1'b1;
        n = 0;
        tr = 1'b0;
        while (!tr && n < 10)
        begin
            run_cyc(t, f, tr);
            n++;
        end
        chk(tr && st.overvoltage_trip === 1'b1 && n >= 2 && n <= 4, "supply over 29V");
        hold_chk();
        s_ov = 1'b0;
        lock();
        $display("test overvoltage done");
    endtask : t_ov

    // the second pass shows the trip repeats and the count restarts clean
    task automatic t_short();
        int t, f, n;
        bit tr;
        vl = 10'h3FF;
        for (int k = 0; k < 2; k++)
        begin
            start(3'h7);
            n = 0;
            tr = 1'b0;
            while (!tr && n < 60)
            begin
                run_cyc(t, f, tr);
                n++;
            end
            chk(tr && st.short_circuit_trip === 1'b1 && n >= 39 && n <= 41, "short trip");
            hold_chk();
            lock();
        end
        $display("test short circuit done");
    endtask : t_short

    // reset for five cycles, then the scenarios in order
    initial
    begin
        repeat (5) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_i = 1'b0;
        @(negedge mclk_i);
        t_thermal();
        t_switch();
        t_ocp();
        t_ov();
        t_short();
        print_verdict();
    end
endmodule : test_ldss_sequencer
